// File: hw/cgl_pkg.sv
// Shared constants and types for the compare greater/less unit
package cgl_pkg;
    // Register map, byte addresses
    localparam logic [3:0] CGL_CTRL_ADDR   = 4'h0;
    localparam logic [3:0] CGL_FAUX_ADDR   = 4'h4;
    localparam logic [3:0] CGL_STATE_ADDR  = 4'h8;
    localparam int         CGL_ADDR_W      = 4;
    // Control register: bit 0 enables instruction issue
    localparam int         CGL_CTRL_EN_BIT = 0;
    localparam logic       CGL_CTRL_RST    = 1'b1;
    // Sticky floating-point status field positions
    localparam int         CGL_F_UNORDERED_FLAG     = 0;
    localparam int         CGL_F_INVALID_FLAG     = 1;
    localparam int         CGL_F_NAN1      = 2;
    localparam int         CGL_F_NAN2      = 3;
    localparam int         CGL_F_DEN1      = 4;
    localparam int         CGL_F_DEN2      = 5;
    localparam int         CGL_FAUX_W      = 6;
    localparam logic [5:0] CGL_FAUX_RST    = 6'h00;
    // Bus responses
    localparam logic [1:0] CGL_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CGL_RESP_SLVERR = 2'h2;
    // Integer opfield values
    localparam logic [6:0] CGL_UGT_REG     = 7'h4f;
    localparam logic [6:0] CGL_UGT_CST     = 7'h4e;
    localparam logic [6:0] CGL_UGT_LREG    = 7'h4d;
    localparam logic [6:0] CGL_UGT_LCST    = 7'h4c;
    localparam logic [6:0] CGL_SLT_REG     = 7'h57;
    localparam logic [6:0] CGL_SLT_CST     = 7'h56;
    localparam logic [6:0] CGL_SLT_LREG    = 7'h55;
    localparam logic [6:0] CGL_SLT_LCST    = 7'h54;
    // Latencies in cycles, then long operand width in bits
    localparam int         CGL_SP_LAT      = 1;
    localparam int         CGL_INT_LAT     = 1;
    localparam int         CGL_DP_LAT      = 2;
    localparam int         CGL_LONG_W      = 40;

    typedef enum logic [1:0] {
        CGL_OP_INT = 2'h0,
        CGL_OP_SP  = 2'h1,
        CGL_OP_DP  = 2'h2
    } cgl_op_t;

    typedef enum logic [1:0] {
        CGL_ST_IDLE = 2'b01,
        CGL_ST_E2   = 2'b10
    } cgl_state_t;

    typedef struct packed {
        logic        sign;
        logic        nan;
        logic        den;
        logic [62:0] mag;
    } cgl_fop_t;
endpackage

// File: hw/cgl_unit.sv
// Compare execution unit: DP/SP greater, unsigned greater, signed less
// Function
// - DP compare reads low words in E1, high words in E2, writes after E2.
// - DP compare sets only unordered/invalid plus per-operand NaN/denormal indicators.
// - SP NaN gives 0 with both flags; zero and denormal compare equal.
// - Unsigned greater compare, register or 4-bit constant first operand.
// - Unsigned greater compare also takes 40-bit long second operand.
// - Only low four bits of 5-bit field form the unsigned constant.
// - Signed less compare, register or 5-bit signed constant first operand.
// - Signed less compare also takes 40-bit signed long second operand.
// - Signed constant only as first operand, register as second.
// - Only second operand may cross path; first from own side.
// - Condition false makes the instruction a no-operation.
// - Integer compares complete in one cycle, no delay slots.
// - DP greater compare writes 1 if first exceeds second, else 0.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cgl_unit (
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    input  wire logic                         clk_en,
    input  wire logic                         issue_valid,
    input  wire cgl_pkg::cgl_op_t             issue_op,
    input  wire logic [6:0]                   opfield,
    input  wire logic [4:0]                   src1_field,
    input  wire logic [4:0]                   dst_field,
    input  wire logic                         cross_sel,
    input  wire logic [2:0]                   cond_sel,
    input  wire logic                         zero_test,
    input  wire logic [31:0]                  cond_value,
    input  wire logic [31:0]                  src1_data,
    input  wire logic [31:0]                  src2_own,
    input  wire logic [31:0]                  src2_cross,
    input  wire logic [7:0]                   src2_hi_data,
    output logic                              issue_ready_q,
    output logic                              wb_valid_q,
    output logic [4:0]                        wb_dst_q,
    output logic [31:0]                       wb_data_q,
    output logic                              unordered_flag_q,
    output logic                              invalid_flag_q,
    output logic [1:0]                        operand_nan_indicator_q,
    output logic [1:0]                        operand_denormal_indicator_q,
    input  wire logic [cgl_pkg::CGL_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [cgl_pkg::CGL_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    import cgl_pkg::*;

    // Split a float into sign, NaN, denormal and ordered magnitude
    function automatic cgl_fop_t cgl_fsplit(input logic [63:0] v, input logic dp);
        logic     e_ones;
        logic     e_zero;
        logic     m_nz;
        cgl_fop_t r;
        e_ones = dp ? (&v[62:52]) : (&v[30:23]);
        e_zero = dp ? (v[62:52] == 11'h000) : (v[30:23] == 8'h00);
        m_nz   = dp ? (v[51:0] != 52'h0) : (v[22:0] != 23'h000000);
        r.sign = dp ? v[63] : v[31];
        r.nan  = e_ones && m_nz;
        r.den  = e_zero && m_nz;
        // Zero and denormal both collapse to magnitude zero
        r.mag  = e_zero ? 63'h0 : (dp ? v[62:0] : {32'h00000000, v[30:0]});
        return r;
    endfunction

    // Ordered greater-than on split operands, NaN handled by caller
    function automatic logic cgl_fgt(input cgl_fop_t a, input cgl_fop_t b);
        logic r;
        case ({a.sign, b.sign})
            2'b00:   r = a.mag > b.mag;
            2'b01:   r = (a.mag != 63'h0) || (b.mag != 63'h0);
            2'b11:   r = a.mag < b.mag;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    cgl_state_t                 st_q, st_d;
    logic [31:0]                a_lo_q, b_lo_q;
    logic [4:0]                 dp_dst_q;
    logic                       dp_cond_q, dp_x_q;
    logic                       ctrl_en_q;
    logic [CGL_FAUX_W-1:0]      faux_q;
    logic [CGL_ADDR_W-1:0]      aw_addr_q;
    logic [31:0]                w_data_q;
    logic [3:0]                 w_strb_q;

    // Issue decode and operand selection
    wire        take      = issue_valid && issue_ready_q;
    wire        cond_true = (cond_sel == 3'h0) || ((cond_value == 32'h0) == zero_test);
    wire [31:0] src2_sel  = cross_sel ? src2_cross : src2_own;
    wire [31:0] e2_src2   = dp_x_q ? src2_cross : src2_own;
    wire        is_ugt    = (opfield[6:2] == CGL_UGT_REG[6:2]);
    wire        is_slt    = (opfield[6:2] == CGL_SLT_REG[6:2]);
    wire        is_long   = !opfield[1];
    wire        is_cst    = !opfield[0];
    wire [39:0] ucst      = {36'h0, src1_field[3:0]};
    wire [39:0] scst      = {{35{src1_field[4]}}, src1_field};
    wire [39:0] s1_reg    = is_ugt ? {8'h00, src1_data} : {{8{src1_data[31]}}, src1_data};
    wire [39:0] s1_val    = is_cst ? (is_ugt ? ucst : scst) : s1_reg;
    wire [39:0] s2_word   = is_ugt ? {8'h00, src2_sel} : {{8{src2_sel[31]}}, src2_sel};
    wire [39:0] s2_val    = is_long ? {src2_hi_data, src2_own} : s2_word;
    wire        ugt_res   = s1_val > s2_val;
    wire        slt_res   = $signed(s1_val) < $signed(s2_val);
    wire        int_res   = is_ugt ? ugt_res : slt_res;

    // Floating-point classification, SP now or DP high words in E2
    wire        e2_now    = (st_q == CGL_ST_E2);
    wire [63:0] fa_raw    = e2_now ? {src1_data, a_lo_q} : {32'h0, src1_data};
    wire [63:0] fb_raw    = e2_now ? {e2_src2, b_lo_q} : {32'h0, src2_sel};
    wire cgl_fop_t fa     = cgl_fsplit(fa_raw, e2_now);
    wire cgl_fop_t fb     = cgl_fsplit(fb_raw, e2_now);
    wire        f_nan     = fa.nan || fb.nan;
    wire        f_res     = !f_nan && cgl_fgt(fa, fb);

    // Writeback next values
    wire        sp_wb     = take && issue_op == CGL_OP_SP && cond_true;
    wire        int_wb    = take && issue_op == CGL_OP_INT && cond_true &&
                            (is_ugt || is_slt);
    wire        dp_wb     = e2_now && dp_cond_q;
    wire        fp_wb     = sp_wb || dp_wb;
    wire        wb_d      = fp_wb || int_wb;
    wire        res_d     = fp_wb ? f_res : int_res;
    wire        dp_take   = take && issue_op == CGL_OP_DP;
    wire [CGL_FAUX_W-1:0] fl_d = fp_wb ? {fb.den, fa.den, fb.nan, fa.nan, f_nan, f_nan}
                                       : {CGL_FAUX_W{1'b0}};

    // Sequencer: DP holds issue closed through E2
    always_comb begin
        case (st_q)
            CGL_ST_IDLE: st_d = dp_take ? CGL_ST_E2 : CGL_ST_IDLE;
            CGL_ST_E2:   st_d = CGL_ST_IDLE;
            default:     st_d = CGL_ST_IDLE;
        endcase
    end

    // Pipeline and result registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q          <= CGL_ST_IDLE;
            issue_ready_q <= 1'b0;
            a_lo_q        <= 32'h0;
            b_lo_q        <= 32'h0;
            dp_dst_q      <= 5'h00;
            dp_cond_q     <= 1'b0;
            dp_x_q        <= 1'b0;
            wb_valid_q    <= 1'b0;
            wb_dst_q      <= 5'h00;
            wb_data_q     <= 32'h0;
            {operand_denormal_indicator_q, operand_nan_indicator_q,
             invalid_flag_q, unordered_flag_q} <= CGL_FAUX_RST;
        end else if (clk_en) begin
            st_q          <= st_d;
            issue_ready_q <= ctrl_en_q && (st_d == CGL_ST_IDLE);
            if (dp_take) begin
                a_lo_q    <= src1_data;
                b_lo_q    <= src2_sel;
                dp_dst_q  <= dst_field;
                dp_cond_q <= cond_true;
                dp_x_q    <= cross_sel;
            end
            wb_valid_q    <= wb_d;
            wb_dst_q      <= dp_wb ? dp_dst_q : dst_field;
            wb_data_q     <= {31'h0, res_d};
            {operand_denormal_indicator_q, operand_nan_indicator_q,
             invalid_flag_q, unordered_flag_q} <= fl_d;
        end
    end

    // Bus decode
    wire aw_hs   = s_axi_awvalid && s_axi_awready;
    wire w_hs    = s_axi_wvalid && s_axi_wready;
    wire ar_hs   = s_axi_arvalid && s_axi_arready;
    wire do_wr   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_ctrl = do_wr && aw_addr_q == CGL_CTRL_ADDR && w_strb_q[0];
    wire wr_faux = do_wr && aw_addr_q == CGL_FAUX_ADDR && w_strb_q[0];
    wire wr_ok   = aw_addr_q == CGL_CTRL_ADDR || aw_addr_q == CGL_FAUX_ADDR ||
                   aw_addr_q == CGL_STATE_ADDR;
    wire rd_ok   = s_axi_araddr == CGL_CTRL_ADDR || s_axi_araddr == CGL_FAUX_ADDR ||
                   s_axi_araddr == CGL_STATE_ADDR;
    wire [31:0] rd_val = (s_axi_araddr == CGL_CTRL_ADDR)  ? {31'h0, ctrl_en_q} :
                         (s_axi_araddr == CGL_FAUX_ADDR)  ? {26'h0, faux_q} :
                         (s_axi_araddr == CGL_STATE_ADDR) ? {30'h0, e2_now, issue_ready_q} :
                         32'h0;
    // Sticky status: a new event wins over a write-one-to-clear
    wire [CGL_FAUX_W-1:0] faux_clr = wr_faux ? w_data_q[CGL_FAUX_W-1:0] : {CGL_FAUX_W{1'b0}};
    wire [CGL_FAUX_W-1:0] faux_d   = (faux_q & ~faux_clr) | fl_d;

    // Write channel: address and data taken in either order
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= CGL_RESP_OKAY;
            aw_addr_q     <= '0;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
            ctrl_en_q     <= CGL_CTRL_RST;
            faux_q        <= CGL_FAUX_RST;
        end else if (clk_en) begin
            if (aw_hs) begin
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? CGL_RESP_OKAY : CGL_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (wr_ctrl) begin
                ctrl_en_q <= w_data_q[CGL_CTRL_EN_BIT];
            end
            faux_q <= faux_d;
        end
    end

    // Read channel: one answer per address, one cycle later
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= CGL_RESP_OKAY;
        end else if (clk_en) begin
            if (ar_hs) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_ok ? CGL_RESP_OKAY : CGL_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Checks, sampled only on enabled edges
    default clocking cgl_cb @(posedge sys_clk iff clk_en);
    endclocking
    default disable iff (!resetn);

    dp_latency_a: assert property (dp_take |=> !wb_valid_q ##1 (wb_valid_q == $past(dp_cond_q)))
        else $error("dp compare result not two cycles after issue");
    dp_issue_block_a: assert property (dp_take |=> !issue_ready_q)
        else $error("issue open during dp second stage");
    fp_flag_pair_a: assert property (wb_valid_q && (operand_nan_indicator_q != 2'h0)
        |-> unordered_flag_q && invalid_flag_q && wb_data_q == 32'h0)
        else $error("nan operand without both flags or with result 1");
    sp_zero_den_a: assert property (sp_wb && fa.mag == 63'h0 && fb.mag == 63'h0 && !f_nan
        |=> wb_data_q == 32'h0 && !unordered_flag_q && !invalid_flag_q)
        else $error("zero or denormal pair not equal");
    sp_single_a: assert property (sp_wb |=> wb_valid_q && wb_data_q[0] == $past(f_res))
        else $error("sp compare not written after one cycle");
    ugt_const_a: assert property (take && issue_op == CGL_OP_INT && cond_true &&
        opfield == CGL_UGT_CST |=> wb_valid_q &&
        wb_data_q[0] == ($past(src1_field[3:0]) > $past(src2_sel)))
        else $error("unsigned constant compare wrong");
    slt_reg_a: assert property (take && issue_op == CGL_OP_INT && cond_true &&
        opfield == CGL_SLT_REG |=> wb_data_q[0] ==
        ($signed($past(src1_data)) < $signed($past(src2_sel))))
        else $error("signed register compare wrong");
    cond_nop_a: assert property (take && !cond_true && issue_op != CGL_OP_DP |=> !wb_valid_q)
        else $error("false condition still wrote");
    word_01_a: assert property (wb_valid_q |-> wb_data_q[31:1] == 31'h0)
        else $error("result upper bits not clear");
    int_flags_a: assert property (int_wb |=> !unordered_flag_q && !invalid_flag_q)
        else $error("integer compare raised fp flag");
    cv_dp: cover property (dp_take ##2 wb_valid_q && wb_data_q[0]);
    cv_sp_nan: cover property (sp_wb && f_nan);
    cv_long: cover property (int_wb && is_long && is_slt);
    cv_clear: cover property (wr_faux && fl_d != '0);
endmodule
`default_nettype wire

// File: verif/cgl_disp_model.sv
// Dispatch and register-file model that feeds the compare unit
`timescale 1ns/100ps
`default_nettype none
module cgl_disp_model (
    input  wire logic        sys_clk,
    input  wire logic        issue_ready_q,
    output logic             issue_valid,
    output cgl_pkg::cgl_op_t issue_op,
    output logic [6:0]       opfield,
    output logic [4:0]       src1_field,
    output logic [4:0]       dst_field,
    output logic             cross_sel,
    output logic [2:0]       cond_sel,
    output logic             zero_test,
    output logic [31:0]      cond_value,
    output logic [31:0]      src1_data,
    output logic [31:0]      src2_own,
    output logic [31:0]      src2_cross,
    output logic [7:0]       src2_hi_data
);
    import cgl_pkg::*;
    // Quiet port at time zero
    initial begin
        issue_op = CGL_OP_INT;
        {issue_valid, opfield, src1_field, dst_field, cross_sel, cond_sel, zero_test} = '0;
        {cond_value, src1_data, src2_own, src2_cross, src2_hi_data} = '0;
    end
    // Second operand on the chosen path, noise on the other
    task automatic put2(input logic x, input logic [31:0] v);
        src2_own   <= x ? ~v : v;
        src2_cross <= x ? v : ~v;
    endtask
    // Offer one instruction until taken; DP high words follow a cycle later
    task automatic issue(input cgl_op_t op, input logic [6:0] opf, input logic [4:0] s1f,
                         input logic [63:0] a, input logic [63:0] b, input logic x,
                         input logic [7:0] hi, input logic [3:0] cz, output logic ok);
        int n;
        @(posedge sys_clk);
        issue_valid  <= 1'b1;
        issue_op     <= op;
        opfield      <= opf;
        src1_field   <= s1f;
        dst_field    <= 5'h0b;
        cross_sel    <= x;
        cond_sel     <= cz[3:1];
        zero_test    <= cz[0];
        cond_value   <= {28'h0, cz};
        src1_data    <= a[31:0];
        src2_hi_data <= hi;
        put2(x, b[31:0]);
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge sys_clk);
            ok = issue_ready_q;
        end
        if (ok && op == CGL_OP_DP) begin
            issue_valid <= 1'b0;
            src1_data   <= a[63:32];
            put2(x, b[63:32]);
            @(posedge sys_clk);
        end
        // Released operands show the inverse of what they held
        issue_valid  <= 1'b0;
        src1_data    <= ~src1_data;
        src2_own     <= ~src2_own;
        src2_cross   <= ~src2_cross;
        src2_hi_data <= ~src2_hi_data;
    endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the compare unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cgl_pkg::*;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        issue_valid, cross_sel, zero_test, issue_ready_q, wb_valid_q;
    logic        unordered_flag_q, invalid_flag_q, ok, clk_en = 1'b1;
    cgl_op_t     issue_op;
    logic [6:0]  opfield;
    logic [4:0]  src1_field, dst_field, wb_dst_q;
    logic [2:0]  cond_sel;
    logic [31:0] cond_value, src1_data, src2_own, src2_cross, wb_data_q, rd, s_axi_rdata;
    logic [7:0]  src2_hi_data;
    logic [1:0]  operand_nan_indicator_q, operand_denormal_indicator_q, rsp;
    logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = '0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          num_errors = 0;
    int          checks = 0;

    // Free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    cgl_unit dut (.sys_clk, .resetn, .clk_en, .issue_valid, .issue_op, .opfield,
        .src1_field, .dst_field, .cross_sel, .cond_sel, .zero_test, .cond_value, .src1_data,
        .src2_own, .src2_cross, .src2_hi_data, .issue_ready_q, .wb_valid_q, .wb_dst_q,
        .wb_data_q, .unordered_flag_q, .invalid_flag_q, .operand_nan_indicator_q,
        .operand_denormal_indicator_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    cgl_disp_model disp (.sys_clk, .issue_ready_q, .issue_valid, .issue_op, .opfield,
        .src1_field, .dst_field, .cross_sel, .cond_sel, .zero_test, .cond_value,
        .src1_data, .src2_own, .src2_cross, .src2_hi_data);

    // Word compare with count
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        checks++;
        if (got !== e) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, e, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic stuck();
        num_errors++;
        give_verdict();
    endtask
    // Bus write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        if (n == 20) stuck();
    endtask
    // Bus read and compare of data and response
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        if (n == 20) stuck();
        chk("read data", e, rd);
        chk("read resp", {30'h0, er}, {30'h0, rsp});
    endtask
    // Issue one instruction and judge the writeback slot that follows
    task automatic run(input cgl_op_t op, input logic [6:0] opf, input logic [4:0] s1f,
            input logic [63:0] a, input logic [63:0] b, input logic x, input logic [7:0] hi,
            input logic [3:0] cz, input logic wv, input logic e, input logic [5:0] fl);
        disp.issue(op, opf, s1f, a, b, x, hi, cz, ok);
        #1;
        chk("issue taken", 32'h1, {31'h0, ok});
        if (!ok) give_verdict();
        chk("wb valid", {31'h0, wv}, {31'h0, wb_valid_q});
        if (wv) begin
            chk("wb data", {31'h0, e}, wb_data_q);
            chk("wb dst", 32'h0b, {27'h0, wb_dst_q});
            chk("flags", {26'h0, fl}, {26'h0, unordered_flag_q, invalid_flag_q,
                operand_nan_indicator_q, operand_denormal_indicator_q});
        end
    endtask
    task automatic ri(input logic [6:0] opf, input logic [4:0] s1f, input logic [31:0] a,
            input logic [31:0] b, input logic x, input logic [7:0] hi, input logic e);
        run(CGL_OP_INT, opf, s1f, {32'h0, a}, {32'h0, b}, x, hi, 4'h0, 1'b1, e, 6'h0);
    endtask
    // Integer compares, every opfield, constants and long pairs
    task automatic test_int();
        ri(CGL_UGT_REG, 5'h00, 32'h128, 32'hffff_ffde, 1'b1, 8'h00, 1'b0);
        ri(CGL_UGT_REG, 5'h00, 32'hffff_ffde, 32'h128, 1'b0, 8'h00, 1'b1);
        ri(CGL_UGT_CST, 5'h0a, 32'h0, 32'h5, 1'b0, 8'h00, 1'b1);
        ri(CGL_UGT_CST, 5'h0a, 32'h0, 32'ha, 1'b0, 8'h00, 1'b0);
        ri(CGL_UGT_LREG, 5'h00, 32'hffff_ffff, 32'h0, 1'b0, 8'h01, 1'b0);
        ri(CGL_UGT_LCST, 5'h0e, 32'h0, 32'ha, 1'b0, 8'h00, 1'b1);
        ri(CGL_SLT_REG, 5'h00, 32'hffff_ffff, 32'h1, 1'b1, 8'h00, 1'b1);
        ri(CGL_SLT_CST, 5'h10, 32'h8000_0000, 32'hffff_fff0, 1'b0, 8'h00, 1'b0);
        ri(CGL_SLT_CST, 5'h1f, 32'h0, 32'h0, 1'b0, 8'h00, 1'b1);
        ri(CGL_SLT_LREG, 5'h00, 32'h0, 32'h0, 1'b0, 8'h80, 1'b0);
        ri(CGL_SLT_LCST, 5'h1f, 32'h0, 32'h0, 1'b0, 8'h00, 1'b1);
        run(CGL_OP_INT, 7'h00, 5'h0, 64'h1, 64'h0, 1'b0, 8'h0, 4'h0, 1'b0, 1'b0, 6'h0);
        run(CGL_OP_INT, CGL_UGT_REG, 5'h0, 64'h1, 64'h0, 1'b0, 8'h0, 4'h3, 1'b0, 1'b0, 6'h0);
        run(CGL_OP_INT, CGL_UGT_REG, 5'h0, 64'h1, 64'h0, 1'b0, 8'h0, 4'h2, 1'b1, 1'b1, 6'h0);
        $display("test integer done");
    endtask
    // Single and double precision, special cases and flags
    task automatic test_fp();
        run(CGL_OP_SP, 7'h0, 5'h0, 64'h7fc0_0000, 64'h3f80_0000, 0, 0, 0, 1, 0, 6'h34);
        run(CGL_OP_SP, 7'h0, 5'h0, 64'h3f80_0000, 64'h7fc0_0000, 0, 0, 0, 1, 0, 6'h38);
        run(CGL_OP_SP, 7'h0, 5'h0, 64'h0, 64'h1, 0, 0, 0, 1, 0, 6'h02);
        run(CGL_OP_SP, 7'h0, 5'h0, 64'hc020_0000, 64'hc109_999a, 1, 0, 0, 1, 1, 6'h0);
        run(CGL_OP_DP, 7'h0, 5'h0, 64'h4021_3333_3333_3333, 64'hc004 << 48,
            0, 0, 0, 1, 1, 6'h0);
        run(CGL_OP_DP, 7'h0, 5'h0, 64'h3ff0_0000_0000_0001, 64'h3ff0 << 48,
            1, 0, 0, 1, 1, 6'h0);
        run(CGL_OP_DP, 7'h0, 5'h0, 64'h7ff8 << 48, 64'h3ff0 << 48, 0, 0, 0, 1, 0, 6'h34);
        run(CGL_OP_DP, 7'h0, 5'h0, 64'h1, 64'h0, 0, 0, 4'h3, 0, 0, 6'h0);
        $display("test float done");
    endtask
    // Register file: sticky status, issue enable, unmapped access
    task automatic test_regs();
        rdchk(CGL_FAUX_ADDR, 32'h2f, CGL_RESP_OKAY);
        axi_wr(CGL_FAUX_ADDR, 32'h2f, rsp);
        rdchk(CGL_FAUX_ADDR, 32'h0, CGL_RESP_OKAY);
        axi_wr(CGL_CTRL_ADDR, 32'h0, rsp);
        rdchk(CGL_STATE_ADDR, 32'h0, CGL_RESP_OKAY);
        disp.issue(CGL_OP_SP, 7'h0, 5'h0, 64'h1, 64'h0, 1'b0, 8'h0, 4'h0, ok);
        chk("refused issue", 32'h0, {31'h0, ok});
        axi_wr(CGL_CTRL_ADDR, 32'h1, rsp);
        rdchk(CGL_STATE_ADDR, 32'h1, CGL_RESP_OKAY);
        axi_wr(4'hc, 32'hffff_ffff, rsp);
        chk("unmapped write resp", {30'h0, CGL_RESP_SLVERR}, {30'h0, rsp});
        rdchk(CGL_CTRL_ADDR, 32'h1, CGL_RESP_OKAY);
        $display("test registers done");
    endtask

    // Clock enable low holds a fresh result in place
    task automatic test_freeze();
        disp.issue(CGL_OP_SP, 7'h0, 5'h0, 64'h3f80_0000, 64'h0, 1'b0, 8'h0, 4'h0, ok);
        clk_en <= 1'b0;
        repeat (2) @(posedge sys_clk);
        clk_en <= 1'b1;
        #1;
        chk("frozen wb valid", 32'h1, {31'h0, wb_valid_q});
        chk("frozen wb data", 32'h1, wb_data_q);
        $display("test freeze done");
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        rdchk(CGL_CTRL_ADDR, 32'h1, CGL_RESP_OKAY);
        rdchk(CGL_FAUX_ADDR, 32'h0, CGL_RESP_OKAY);
        rdchk(4'hc, 32'h0, CGL_RESP_SLVERR);
        $display("test reset done");
        test_int();
        test_fp();
        test_regs();
        test_freeze();
        give_verdict();
    end
    // Hang guard
    initial begin
        #200000;
        stuck();
    end
endmodule
`default_nettype wire
